//--- core/lcm_cell.sv
// Programmable logic cell: lookup table, one register, carry and cascade chaining.
// Assumes all cell inputs and control lines are synchronous to sys_clk and the
// register port master never asserts both strobes in one cycle.
`timescale 1ns/10ps
module lcm_cell
   import lcm_pkg::*;
#(
   parameter int TRI_N = LCM_TRI_N
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [LCM_ADDR_W-1:0] reg_addr,
   input wire logic [LCM_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [LCM_DATA_W-1:0] reg_rdata,
   input wire lcm_in_t cell_in,
   input wire lcm_ctl_t cell_ctl,
   input wire logic [TRI_N-1:0] tri_data,
   input wire logic [TRI_N-1:0] tri_en,
   output lcm_out_t cell_out,
   output logic tri_bus_out
);

   function automatic logic lut3(input logic [LCM_LUT3_W-1:0] mask, input logic [2:0] idx);
      return mask[idx];
   endfunction : lut3

   // OR is built from the AND by De Morgan inversion of both inputs and output
   function automatic logic casc_join(input logic f, input logic cin, input logic use_it,
                                      input logic is_or);
      logic r;
      r = f;
      if (use_it) begin
         if (is_or) begin
            r = ~((~f) & (~cin));
         end else begin
            r = f & cin;
         end
      end
      return r;
   endfunction : casc_join

   // Returns {clr_n, pre_n, inv}; unused clear or preset stays high
   function automatic logic [2:0] async_decode(input lcm_async_t m, input logic c1,
                                               input logic c2, input logic ld);
      logic clr_n;
      logic pre_n;
      logic inv;
      clr_n = 1'b1;
      pre_n = 1'b1;
      inv = 1'b0;
      case (m)
         LCM_AS_CLR: begin
            clr_n = ~(c1 | c2);
         end
         LCM_AS_PRE: begin
            pre_n = ~c1;
         end
         LCM_AS_CLRPRE: begin
            pre_n = ~c1;
            clr_n = ~c2;
         end
         LCM_AS_LDCLR: begin
            pre_n = ~(c1 & ld);
            clr_n = ~((c1 & ~ld) | c2);
         end
         LCM_AS_LDPRE: begin
            inv = 1'b1;
            pre_n = ~(c1 & ~ld);
            clr_n = ~((c1 & ld) | c2);
         end
         LCM_AS_LD: begin
            pre_n = ~(c1 & ld);
            clr_n = ~(c1 & ~ld);
         end
         default: begin
            clr_n = 1'b1;
            pre_n = 1'b1;
         end
      endcase
      return {clr_n, pre_n, inv};
   endfunction : async_decode

   lcm_state_t st_reg;
   lcm_state_t st_next;

   logic d1;
   logic d2;
   logic d3;
   logic d4;
   logic cin;
   logic casc_in;
   logic c1;
   logic c2;
   logic chip_rst_act;
   logic tri_level;
   logic lut_c;
   logic [3:0] idx4;
   logic lut4_out;
   logic [2:0] idx3;
   logic casc_use;
   logic comb_res;
   logic carry_o;
   logic d_val;
   logic d_int;
   logic ld_mux;
   logic cnt_val;
   logic ce;
   logic clr_n;
   logic pre_n;
   logic inv;
   logic q_vis;
   logic async_idle;
   lcm_stat_t stat;

   assign d1 = cell_in.first_data_input;
   assign d2 = cell_in.second_data_input;
   assign d3 = cell_in.third_data_input;
   assign d4 = cell_in.fourth_data_input;
   assign cin = cell_in.carry_in;
   assign casc_in = cell_in.cascade_in;
   assign c1 = cell_ctl.cluster_control_line_one;
   assign c2 = cell_ctl.cluster_control_line_two;

   lcm_tri_emul #(
      .N(TRI_N)
   ) u_tri (
      .tri_data(tri_data),
      .tri_en(tri_en),
      .bus_level(tri_level)
   );

   always_comb begin
      st_next = st_reg;
      chip_rst_act = st_reg.cfg.chip_rst_en & ~cell_ctl.chip_reset_n;
      {clr_n, pre_n, inv} = async_decode(st_reg.cfg.async_mode, c1, c2, d3);
      // Visible value; load-with-preset keeps the complement inside
      q_vis = st_reg.q_int ^ inv;
      async_idle = clr_n & pre_n & ~chip_rst_act;
      // Packed register steals the cascade path, so packing wins
      casc_use = st_reg.cfg.cascade_en & ~st_reg.cfg.pack_en;
      lut_c = st_reg.cfg.carry_sel_cin ? cin : d3;
      idx4 = {d4, lut_c, d2, d1};
      lut4_out = st_reg.lut[idx4];
      idx3 = {cin, d2, d1};
      comb_res = 1'b0;
      carry_o = 1'b0;
      d_val = 1'b0;
      ld_mux = 1'b0;
      cnt_val = 1'b0;
      case (st_reg.cfg.op)
         LCM_OP_NORMAL: begin
            comb_res = casc_join(lut4_out, casc_in, casc_use, st_reg.cfg.cascade_or);
            d_val = st_reg.cfg.pack_en ? d4 : comb_res;
         end
         LCM_OP_ARITH: begin
            comb_res = casc_join(lut3(st_reg.lut[LCM_LUT3_W-1:0], idx3), casc_in,
                                 st_reg.cfg.cascade_en, st_reg.cfg.cascade_or);
            carry_o = lut3(st_reg.lut[LCM_LUT_W-1:LCM_LUT3_W], idx3);
            d_val = comb_res;
         end
         LCM_OP_UPDN: begin
            // Direction on the second input, count enable rides the carry-in
            cnt_val = lut3(st_reg.lut[LCM_LUT3_W-1:0], {cin, d2, q_vis});
            carry_o = lut3(st_reg.lut[LCM_LUT_W-1:LCM_LUT3_W], {cin, d2, q_vis});
            ld_mux = d4 ? d3 : cnt_val;
            comb_res = cnt_val;
            d_val = ld_mux;
         end
         LCM_OP_CLRCNT: begin
            // Cascade-in serves as the active-low synchronous clear here
            cnt_val = lut3(st_reg.lut[LCM_LUT3_W-1:0], {cin, 1'b1, q_vis});
            carry_o = lut3(st_reg.lut[LCM_LUT_W-1:LCM_LUT3_W], {cin, 1'b1, q_vis});
            ld_mux = d4 ? d3 : cnt_val;
            comb_res = cnt_val;
            d_val = ld_mux & casc_in;
         end
         default: begin
            comb_res = 1'b0;
            d_val = q_vis;
         end
      endcase
      d_int = d_val ^ inv;
      ce = ~st_reg.cfg.ce_from_d1 | d1;

      // Asynchronous controls act at the next edge regardless of enable
      if (chip_rst_act) begin
         st_next.q_int = 1'b0;
      end else if (!clr_n) begin
         st_next.q_int = 1'b0;
      end else if (!pre_n) begin
         st_next.q_int = 1'b1;
      end else if (ce) begin
         st_next.q_int = d_int;
      end

      st_next.outs.local_out = st_reg.cfg.local_src_reg ? q_vis : comb_res;
      st_next.outs.global_out = st_reg.cfg.global_src_reg ? q_vis : comb_res;
      st_next.outs.carry_out = carry_o;
      st_next.outs.cascade_out = comb_res;
      st_next.tri_out = tri_level;

      stat.outs = st_reg.outs;
      stat.cfg_conflict = st_reg.cfg.pack_en & st_reg.cfg.cascade_en;
      stat.reg_q = q_vis;

      if (reg_wr) begin
         if (reg_addr == LCM_OFS_CFG) begin
            st_next.cfg = lcm_cfg_t'(reg_wdata[LCM_CFG_W-1:0]);
         end else if (reg_addr == LCM_OFS_LUT) begin
            st_next.lut = reg_wdata[LCM_LUT_W-1:0];
         end
      end

      // Read data stand for one cycle only; unmapped offsets read zero
      st_next.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            LCM_OFS_CFG: st_next.rdata = {{(LCM_DATA_W-LCM_CFG_W){1'b0}}, st_reg.cfg};
            LCM_OFS_LUT: st_next.rdata = {{(LCM_DATA_W-LCM_LUT_W){1'b0}}, st_reg.lut};
            LCM_OFS_STAT: st_next.rdata = {{(LCM_DATA_W-LCM_STAT_W){1'b0}}, stat};
            default: st_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= LCM_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign cell_out = st_reg.outs;
   assign tri_bus_out = st_reg.tri_out;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_chip_rst;
      chip_rst_act;
   endsequence

   sequence s_line_one_only;
      c1 && !c2 && !chip_rst_act;
   endsequence

   sequence s_line_two_only;
      c2 && !c1 && !chip_rst_act;
   endsequence

   property p_mode_hit(lcm_async_t m, logic hit);
      (st_reg.cfg.async_mode == m) && hit;
   endproperty

   chip_reset_clear_a: assert property (s_chip_rst |=> st_reg.q_int == 1'b0)
      else $error("chip reset did not clear register");

   async_clear_mode_a: assert property ((st_reg.cfg.async_mode == LCM_AS_CLR)
      && (c1 || c2) && !chip_rst_act |=> !q_vis)
      else $error("clear mode line did not clear");

   clear_preset_set_a: assert property ((st_reg.cfg.async_mode == LCM_AS_CLRPRE)
      ##0 s_line_one_only |=> q_vis)
      else $error("line one did not preset");

   async_load_a: assert property (((st_reg.cfg.async_mode == LCM_AS_LD)
      || (st_reg.cfg.async_mode == LCM_AS_LDCLR)) ##0 s_line_one_only
      |=> q_vis == $past(d3))
      else $error("asynchronous load missed third input");

   load_clear_only_a: assert property ((st_reg.cfg.async_mode == LCM_AS_LDCLR)
      ##0 s_line_two_only |=> !q_vis)
      else $error("line two did not clear");

   load_preset_a: assert property ((st_reg.cfg.async_mode == LCM_AS_LDPRE)
      ##0 s_line_two_only |=> q_vis && !st_reg.q_int)
      else $error("inverted preset failed");

   enable_hold_a: assert property (async_idle && !ce && $stable(st_reg.cfg)
      |=> $stable(st_reg.q_int))
      else $error("register changed with enable low");

   packed_d4_a: assert property ((st_reg.cfg.op == LCM_OP_NORMAL) && st_reg.cfg.pack_en
      && async_idle && ce && $stable(st_reg.cfg) |=> q_vis == $past(d4))
      else $error("packed register missed fourth input");

   arith_carry_a: assert property ((st_reg.cfg.op == LCM_OP_ARITH)
      |=> cell_out.carry_out == $past(st_reg.lut[{1'b1, idx3}]))
      else $error("carry-out table mismatch");

   sync_clear_a: assert property ((st_reg.cfg.op == LCM_OP_CLRCNT) && !casc_in
      && async_idle && ce && !inv |=> !st_reg.q_int)
      else $error("synchronous clear ignored");

   pack_no_cascade_a: assert property ((st_reg.cfg.op == LCM_OP_NORMAL)
      && st_reg.cfg.pack_en |=> cell_out.cascade_out == $past(lut4_out))
      else $error("cascade used in packed cell");

   updn_load_a: assert property ((st_reg.cfg.op == LCM_OP_UPDN) && d4 && async_idle
      && ce && !inv |=> st_reg.q_int == $past(d3))
      else $error("synchronous load missed third input");

   local_src_a: assert property (st_reg.cfg.local_src_reg
      |=> cell_out.local_out == $past(q_vis))
      else $error("local output not from register");

   tri_float_high_a: assert property (tri_en == '0 |=> tri_bus_out)
      else $error("floating bus not high");

   tri_contend_low_a: assert property ($countones(tri_en) > 1 |=> !tri_bus_out)
      else $error("contending bus not low");

   read_pulse_a: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data held past its cycle");

endmodule : lcm_cell

//--- core/lcm_pkg.sv
// Shared types and constants of the programmable logic cell.
// Assumes a single clock domain; every user of these types imports lcm_pkg::*.
package lcm_pkg;

   localparam int LCM_ADDR_W = 4;
   localparam int LCM_DATA_W = 32;
   localparam int LCM_LUT_W = 16;
   localparam int LCM_LUT3_W = 8;
   localparam int LCM_TRI_N = 4;

   localparam logic [LCM_ADDR_W-1:0] LCM_OFS_CFG = 4'h0;
   localparam logic [LCM_ADDR_W-1:0] LCM_OFS_LUT = 4'h4;
   localparam logic [LCM_ADDR_W-1:0] LCM_OFS_STAT = 4'h8;

   localparam logic [LCM_LUT_W-1:0] LCM_LUT_RST = 16'h0000;

   // Operating modes, one-hot
   typedef enum logic [3:0] {
      LCM_OP_NORMAL = 4'b0001,
      LCM_OP_ARITH = 4'b0010,
      LCM_OP_UPDN = 4'b0100,
      LCM_OP_CLRCNT = 4'b1000
   } lcm_op_t;

   // Asynchronous clear and preset configurations, one-hot
   typedef enum logic [5:0] {
      LCM_AS_CLR = 6'b000001,
      LCM_AS_PRE = 6'b000010,
      LCM_AS_CLRPRE = 6'b000100,
      LCM_AS_LDCLR = 6'b001000,
      LCM_AS_LDPRE = 6'b010000,
      LCM_AS_LD = 6'b100000
   } lcm_async_t;

   typedef struct packed {
      logic chip_rst_en;
      logic ce_from_d1;
      logic cascade_or;
      logic cascade_en;
      logic pack_en;
      logic global_src_reg;
      logic local_src_reg;
      logic carry_sel_cin;
      lcm_async_t async_mode;
      lcm_op_t op;
   } lcm_cfg_t;

   localparam int LCM_CFG_W = $bits(lcm_cfg_t);

   localparam lcm_cfg_t LCM_CFG_RST = '{
      chip_rst_en: 1'b1, ce_from_d1: 1'b0, cascade_or: 1'b0, cascade_en: 1'b0,
      pack_en: 1'b0, global_src_reg: 1'b0, local_src_reg: 1'b0,
      carry_sel_cin: 1'b0, async_mode: LCM_AS_CLR, op: LCM_OP_NORMAL};

   typedef struct packed {
      logic first_data_input;
      logic second_data_input;
      logic third_data_input;
      logic fourth_data_input;
      logic carry_in;
      logic cascade_in;
   } lcm_in_t;

   typedef struct packed {
      logic cluster_control_line_one;
      logic cluster_control_line_two;
      logic chip_reset_n;
   } lcm_ctl_t;

   typedef struct packed {
      logic local_out;
      logic global_out;
      logic carry_out;
      logic cascade_out;
   } lcm_out_t;

   typedef struct packed {
      lcm_out_t outs;
      logic cfg_conflict;
      logic reg_q;
   } lcm_stat_t;

   localparam int LCM_STAT_W = $bits(lcm_stat_t);

   typedef struct packed {
      lcm_cfg_t cfg;
      logic [LCM_LUT_W-1:0] lut;
      logic q_int;
      lcm_out_t outs;
      logic tri_out;
      logic [LCM_DATA_W-1:0] rdata;
   } lcm_state_t;

   localparam lcm_state_t LCM_STATE_RST = '{
      cfg: LCM_CFG_RST, lut: LCM_LUT_RST, q_int: 1'b0, outs: '0,
      tri_out: 1'b1, rdata: '0};

endpackage : lcm_pkg

//--- core/lcm_tri_emul.sv
// Multiplexer-based emulation of an internal tri-state bus.
// Assumes enables and data are synchronous levels; output is combinational.
`timescale 1ns/10ps
module lcm_tri_emul #(
   parameter int N = 4
) (
   input wire logic [N-1:0] tri_data,
   input wire logic [N-1:0] tri_en,
   output logic bus_level
);

   localparam logic [N-1:0] ONE = {{(N-1){1'b0}}, 1'b1};

   logic none_on;
   logic one_on;

   // Contention resolves low, a floating bus resolves high
   always_comb begin
      none_on = (tri_en == '0);
      one_on = !none_on && ((tri_en & (tri_en - ONE)) == '0);
      if (none_on) begin
         bus_level = 1'b1;
      end else if (one_on) begin
         bus_level = |(tri_en & tri_data);
      end else begin
         bus_level = 1'b0;
      end
   end

endmodule : lcm_tri_emul

//--- dv/lcm_nbr_model.sv
// Upstream neighbour cell: drives the carry and cascade chain into the cell.
// Assumes the bench commands the chain levels by non-blocking assignment at sys_clk.
`timescale 1ns/10ps
module lcm_nbr_model (
   input wire logic sys_clk,
   input wire logic carry_cmd,
   input wire logic casc_cmd,
   output logic carry_in,
   output logic cascade_in
);
   // A real neighbour drives its chain outputs from registers, so they move after an edge
   always @(posedge sys_clk) begin
      carry_in <= carry_cmd;
      cascade_in <= casc_cmd;
   end
endmodule : lcm_nbr_model

//--- dv/lcm_cell_tb.sv
// Self-checking bench of the logic cell: register port, datapath, async controls.
// Assumes lcm_pkg and lcm_cell are compiled first; the neighbour model feeds the chains.
`timescale 1ns/10ps
module lcm_cell_tb;
   import lcm_pkg::*;
   logic sys_clk, rst_n, reg_wr, reg_rd, carry_cmd, casc_cmd, nb_carry, nb_casc, tri_bus_out;
   logic [LCM_ADDR_W-1:0] reg_addr;
   logic [LCM_DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
   logic [3:0] dat;
   logic [LCM_TRI_N-1:0] tri_data, tri_en;
   lcm_ctl_t ctl;
   lcm_in_t cell_in;
   lcm_out_t cell_out;
   int err_total, tests_run;

   // dat[3] is the first data input, dat[0] the fourth
   assign cell_in = {dat, nb_carry, nb_casc};

   lcm_cell uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cell_in(cell_in),
      .cell_ctl(ctl), .tri_data(tri_data), .tri_en(tri_en), .cell_out(cell_out),
      .tri_bus_out(tri_bus_out));

   lcm_nbr_model nbr (.sys_clk(sys_clk), .carry_cmd(carry_cmd), .casc_cmd(casc_cmd),
      .carry_in(nb_carry), .cascade_in(nb_casc));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic settle(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : rd

   // Flags: chip_rst_en, ce_from_d1, cascade_or, cascade_en, pack, global_reg, local_reg, cin_sel
   task automatic cfg(lcm_op_t op, lcm_async_t am, logic [7:0] fl);
      wr(LCM_OFS_CFG, {14'h0, fl, am, op});
   endtask : cfg

   task automatic drv(logic [3:0] d, logic c, logic k);
      @(posedge sys_clk);
      dat <= d;
      carry_cmd <= c;
      casc_cmd <= k;
      settle(3);
   endtask : drv

   task automatic q_is(string nm, logic e);
      rd(LCM_OFS_STAT);
      chk(nm, {31'h0, e}, rd_val & 32'h1);
   endtask : q_is

   // Clock enable is kept off through dat, so only the control lines move the register
   task automatic pulse(lcm_ctl_t c, logic d3);
      @(posedge sys_clk);
      ctl <= c;
      dat <= {2'b00, d3, 1'b0};
      @(posedge sys_clk);
      ctl <= 3'b001;
   endtask : pulse

   task automatic t_reset;
      rd(LCM_OFS_CFG);
      chk("cfg reset", 32'(LCM_CFG_RST), rd_val);
      rd(LCM_OFS_LUT);
      chk("lut reset", 32'h0, rd_val);
      rd(4'hc);
      chk("unmapped read", 32'h0, rd_val);
      chk("outs reset", 32'h0, 32'(cell_out));
   endtask : t_reset

   task automatic t_normal;
      wr(LCM_OFS_LUT, 32'h8000);
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'h80);
      drv(4'hf, 1'b0, 1'b1);
      chk("local lut", 32'h1, 32'(cell_out.local_out));
      chk("global lut", 32'h1, 32'(cell_out.global_out));
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'h81);
      settle(2);
      chk("carry as input", 32'h0, 32'(cell_out.local_out));
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'h91);
      drv(4'hf, 1'b1, 1'b0);
      chk("cascade and low", 32'h0, 32'(cell_out.cascade_out));
      drv(4'hf, 1'b1, 1'b1);
      chk("cascade and high", 32'h1, 32'(cell_out.cascade_out));
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'hb1);
      drv(4'h0, 1'b1, 1'b1);
      chk("cascade or", 32'h1, 32'(cell_out.cascade_out));
   endtask : t_normal

   task automatic t_pack;
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'h8c);
      drv(4'h1, 1'b0, 1'b1);
      chk("packed reg", 32'h1, 32'(cell_out.global_out));
      chk("packed lut", 32'h0, 32'(cell_out.local_out));
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'h8a);
      settle(2);
      chk("local reg", 32'h1, 32'(cell_out.local_out));
      chk("global packed lut", 32'h0, 32'(cell_out.global_out));
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'h9c);
      rd(LCM_OFS_STAT);
      chk("pack conflict", 32'h2, rd_val & 32'h2);
      cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'hcc);
      drv(4'h0, 1'b0, 1'b1);
      q_is("enable off", 1'b1);
      drv(4'h8, 1'b0, 1'b1);
      q_is("enable on", 1'b0);
   endtask : t_pack

   task automatic t_arith;
      logic [7:0] sum_t, cy_t;
      sum_t = 8'h96;
      cy_t = 8'he8;
      wr(LCM_OFS_LUT, {16'h0, cy_t, sum_t});
      cfg(LCM_OP_ARITH, LCM_AS_CLR, 8'h80);
      for (int i = 0; i < 8; i++) begin
         drv({i[0], i[1], 2'b00}, i[2], 1'b1);
         chk("sum", 32'(sum_t[i]), 32'(cell_out.local_out));
         chk("carry out", 32'(cy_t[i]), 32'(cell_out.carry_out));
      end
   endtask : t_arith

   task automatic t_count;
      wr(LCM_OFS_LUT, 32'h005a);
      cfg(LCM_OP_UPDN, LCM_AS_CLR, 8'h80);
      drv(4'h3, 1'b0, 1'b1);
      q_is("sync load", 1'b1);
      @(posedge sys_clk);
      dat <= 4'h0;
      carry_cmd <= 1'b1;
      @(posedge sys_clk);
      carry_cmd <= 1'b0;
      settle(3);
      q_is("count step", 1'b0);
      cfg(LCM_OP_CLRCNT, LCM_AS_CLR, 8'h80);
      drv(4'h3, 1'b0, 1'b1);
      q_is("clear released", 1'b1);
      drv(4'h3, 1'b0, 1'b0);
      q_is("sync clear", 1'b0);
   endtask : t_count

   task automatic t_async;
      cfg(LCM_OP_NORMAL, LCM_AS_CLRPRE, 8'hc0);
      pulse(3'b101, 1'b0);
      q_is("line one sets", 1'b1);
      pulse(3'b011, 1'b0);
      q_is("line two clears", 1'b0);
      for (int k = 0; k < 2; k++) begin
         cfg(LCM_OP_NORMAL, LCM_AS_CLRPRE, 8'hc0);
         pulse(3'b101, 1'b0);
         cfg(LCM_OP_NORMAL, LCM_AS_CLR, 8'hc0);
         pulse(k ? 3'b011 : 3'b101, 1'b0);
         q_is("clear line", 1'b0);
      end
      cfg(LCM_OP_NORMAL, LCM_AS_LD, 8'hc0);
      pulse(3'b101, 1'b1);
      q_is("load one", 1'b1);
      pulse(3'b101, 1'b0);
      q_is("load zero", 1'b0);
      cfg(LCM_OP_NORMAL, LCM_AS_LDCLR, 8'hc0);
      pulse(3'b101, 1'b1);
      pulse(3'b011, 1'b1);
      q_is("load clear", 1'b0);
      cfg(LCM_OP_NORMAL, LCM_AS_LDPRE, 8'hc0);
      pulse(3'b101, 1'b0);
      q_is("inverted load", 1'b0);
      pulse(3'b011, 1'b0);
      q_is("inverted preset", 1'b1);
      // Load a zero first so the reset check can see the register move
      pulse(3'b101, 1'b0);
      pulse(3'b100, 1'b0);
      q_is("chip reset preset", 1'b1);
      cfg(LCM_OP_NORMAL, LCM_AS_CLRPRE, 8'hc0);
      pulse(3'b101, 1'b0);
      pulse(3'b100, 1'b0);
      q_is("chip reset wins", 1'b0);
   endtask : t_async

   task automatic t_tri;
      logic [3:0] en_v[4] = '{4'h0, 4'h3, 4'h4, 4'h4};
      logic [3:0] da_v[4] = '{4'h0, 4'hf, 4'h0, 4'h4};
      logic ex_v[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         tri_en <= en_v[i];
         tri_data <= da_v[i];
         settle(2);
         chk("emulated bus", 32'(ex_v[i]), 32'(tri_bus_out));
      end
   endtask : t_tri

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   // Whole run is a few hundred cycles; the limit leaves wide margin
   initial begin
      #2000000;
      err_total++;
      wrap_up();
   end

   initial begin
      err_total = 0;
      tests_run = 0;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      dat = 4'h0;
      carry_cmd = 1'b0;
      casc_cmd = 1'b1;
      ctl = 3'b001;
      tri_data = 4'h0;
      tri_en = 4'h0;
      repeat (12) @(posedge sys_clk);
      chk("bus idle high", 32'h1, 32'(tri_bus_out));
      rst_n <= 1'b1;
      t_reset();
      t_normal();
      t_pack();
      t_arith();
      t_count();
      t_async();
      t_tri();
      wrap_up();
   end
endmodule : lcm_cell_tb
